//--- logic/rwc_pkg.sv
`default_nettype none
package rwc_pkg;
  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PIN_MIN_PULSE_NS = 400;
  localparam int unsigned PIN_MIN_CYCLES = (PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DROP_MIN_NS = 2000;
  localparam int unsigned DROP_MIN_CYCLES = (DROP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned UNLOCK_CYCLES = 4;
  // Watchdog period: 2048 oscillator cycles at code zero, doubling per step
  localparam int unsigned DOG_BASE_LOG2 = 11;
  localparam logic [3:0] DOG_PSEL_MAX = 4'h9;
  localparam int unsigned DOG_CNT_W = 20;
  localparam int unsigned DELAY_W = 16;
  // Supply-drop level code that switches the detector off
  localparam logic [2:0] DROP_LEVEL_OFF = 3'h7;
  // Register map, byte addresses
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_CONTROL = 4'h4;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  typedef enum logic [1:0] {
    RWC_DOG_STOPPED = 2'b00,
    RWC_DOG_IRQ = 2'b01,
    RWC_DOG_RESET = 2'b10,
    RWC_DOG_BOTH = 2'b11
  } rwc_dog_mode_e;

  typedef struct packed {
    logic [3:0] zero;
    logic dog_reset_seen_flag;
    logic supply_drop_reset_flag;
    logic pin_reset_flag;
    logic power_up_reset_flag;
  } rwc_cause_s;

  typedef struct packed {
    logic watchdog_irq_flag;
    logic watchdog_irq_enable;
    logic psel_hi;
    logic watchdog_change_unlock;
    logic watchdog_reset_enable;
    logic [2:0] psel_lo;
  } rwc_wdctl_s;

  typedef struct packed {
    logic run;
    logic [3:0] psel;
  } rwc_dog_cfg_s;
endpackage
`default_nettype wire

//--- logic/rwc_dog_counter.sv
`timescale 1ns/10ps
`default_nettype none
module rwc_dog_counter #(
  parameter int unsigned CNT_W = rwc_pkg::DOG_CNT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Control
  input wire rwc_pkg::rwc_dog_cfg_s cfg,
  input wire logic restart,
  input wire logic osc_tick,
  // Expiry event
  output logic timeout_r
);
  import rwc_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic timeout_nxt;

  // Last count of a period; reserved codes run at the longest period
  function automatic logic [CNT_W-1:0] last_count(input logic [3:0] psel);
    logic [3:0] code;
    code = (psel > DOG_PSEL_MAX) ? DOG_PSEL_MAX : psel;
    last_count = CNT_W'((32'h1 << (DOG_BASE_LOG2 + 32'(code))) - 32'h1);
  endfunction

  // Counts oscillator ticks; >= keeps a shortened period from wrapping
  always_comb begin
    cnt_nxt = cnt_r;
    timeout_nxt = 1'b0;
    if (!cfg.run || restart) begin
      cnt_nxt = '0; // R14
    end else if (osc_tick) begin
      if (cnt_r >= last_count(cfg.psel)) begin // R13 R23
        cnt_nxt = '0;
        timeout_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + CNT_W'(1);
      end
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      timeout_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      timeout_r <= timeout_nxt;
    end
  end
endmodule // rwc_dog_counter
`default_nettype wire

//--- logic/rwc_startup_delay.sv
`timescale 1ns/10ps
`default_nettype none
module rwc_startup_delay #(
  parameter int unsigned DW = rwc_pkg::DELAY_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Reset request and delay length
  input wire logic hold,
  input wire logic [DW-1:0] delay_cycles,
  // Stretched reset
  output logic in_reset_r
);
  import rwc_pkg::*;

  logic [DW-1:0] cnt_r;
  logic [DW-1:0] cnt_nxt;
  logic in_reset_nxt;

  // Count starts only once every source has let go
  always_comb begin
    cnt_nxt = cnt_r;
    in_reset_nxt = in_reset_r;
    if (hold) begin
      cnt_nxt = '0;
      in_reset_nxt = 1'b1;
    end else if (in_reset_r) begin
      if (cnt_r >= delay_cycles) begin // R25
        in_reset_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r + DW'(1);
      end
    end
  end

  // Power-up also runs one full delay
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      in_reset_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      in_reset_r <= in_reset_nxt;
    end
  end
endmodule // rwc_startup_delay
`default_nettype wire

//--- logic/rwc_reset_watchdog.sv
// Behaviour
// R01 - Pin held low past the minimum pulse width resets; shorter pulses may not.
// R02 - After the pin rises, reset holds until the start-up delay expires.
// R03 - Three-bit level code 111 disables the supply-drop detector; others enable it.
// R04 - Enabled detector asserts supply-drop reset at once when supply falls low.
// R05 - Supply drops shorter than about 2 us are ignored.
// R06 - After supply recovers, reset releases only after the start-up delay.
// R07 - Watchdog reset pulse lasts exactly one clock cycle.
// R08 - Start-up delay starts when the watchdog pulse falls.
// R09 - Status bit 3 set by watchdog reset; cleared by power-up or writing zero.
// R10 - Status bit 2 set by supply-drop reset; cleared by power-up or zero write.
// R11 - Status bit 1 set by pin reset; cleared by power-up or zero write.
// R12 - Status bit 0 set by power-up; cleared only by software writing zero.
// R13 - Watchdog counts oscillator ticks; at timeout raises interrupt or reset.
// R14 - Restart instruction before timeout clears the watchdog count to zero.
// R15 - Modes: interrupt, reset, or interrupt first then reset.
// R16 - Watchdog keeps counting while the core sleeps, so it can wake it.
// R17 - Timeout selectable from about 16 ms to about 8 s.
// R18 - Always-on fuse forces reset enable one and interrupt enable zero.
// R19 - Unlock by writing change-enable and reset-enable both one together.
// R20 - Within four cycles, one write with change-enable zero sets enable and prescaler.
// R21 - Change-enable clears itself four cycles after being set.
// R22 - Watchdog reset flag forces reset enable on; it cannot be cleared meanwhile.
// R23 - Prescaler 0000 gives 2048 cycles, doubling up to 1001; higher reserved.
// R24 - Interrupt flag set on timeout; cleared by vector or writing one.
// R25 - System reset holds from first source until the configured delay ends.
// R26 - Status bits read as one byte; bits seven to four read zero.
`timescale 1ns/10ps
`default_nettype none
module rwc_reset_watchdog #(
  parameter int unsigned DELAY_W = rwc_pkg::DELAY_W
) (
  // Clock and power-up reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Reset sources and configuration
  input wire logic reset_pin_n,
  input wire logic supply_low,
  input wire logic [2:0] supply_drop_level_select,
  input wire logic [DELAY_W-1:0] startup_delay_period,
  // Watchdog side inputs
  input wire logic dog_osc_tick,
  input wire logic dog_restart,
  input wire logic dog_irq_ack,
  input wire logic watchdog_always_on_fuse,
  // Results
  output logic sys_reset,
  output logic dog_irq
);
  import rwc_pkg::*;

  localparam int unsigned PIN_W = $clog2(PIN_MIN_CYCLES + 1);
  localparam int unsigned DROP_W = $clog2(DROP_MIN_CYCLES + 1);
  localparam int unsigned UNL_W = $clog2(UNLOCK_CYCLES);

  // Mode from the effective enables
  function automatic rwc_dog_mode_e dog_mode(input logic irq_on, input logic rst_on);
    dog_mode = rwc_dog_mode_e'({rst_on, irq_on});
  endfunction

  logic [PIN_W-1:0] pin_cnt_r, pin_cnt_nxt;
  logic [DROP_W-1:0] drop_cnt_r, drop_cnt_nxt;
  logic pin_hold, drop_en, drop_hold, hold;
  logic dog_pulse_r, dog_pulse_nxt;
  rwc_cause_s cause_r, cause_nxt;
  logic irq_flag_r, irq_flag_nxt, irq_en_r, irq_en_nxt, rst_en_r, rst_en_nxt;
  logic [3:0] psel_r, psel_nxt;
  logic unlock_r, unlock_nxt;
  logic [UNL_W-1:0] ucnt_r, ucnt_nxt;
  logic dog_irq_nxt;
  logic eff_irq, eff_rst, fire_irq, fire_rst, timeout;
  rwc_dog_mode_e mode;
  rwc_wdctl_s wd, ctl_rd;
  rwc_dog_cfg_s dog_cfg;
  logic wait_nxt, req, acc_wr, wr_status, wr_ctl;
  logic [31:0] rdata_nxt;

  // Reset source qualification: pin and supply comparator filtered by counters
  assign drop_en = (supply_drop_level_select != DROP_LEVEL_OFF); // R03
  assign pin_hold = !reset_pin_n && (pin_cnt_r == PIN_W'(PIN_MIN_CYCLES)); // R01
  assign drop_hold = drop_en && supply_low && (drop_cnt_r == DROP_W'(DROP_MIN_CYCLES)); // R04 R05
  assign hold = pin_hold || drop_hold || dog_pulse_r; // R25

  always_comb begin
    pin_cnt_nxt = '0;
    drop_cnt_nxt = '0;
    if (!reset_pin_n) begin
      pin_cnt_nxt = (pin_cnt_r == PIN_W'(PIN_MIN_CYCLES)) ? pin_cnt_r : pin_cnt_r + PIN_W'(1);
    end
    if (drop_en && supply_low) begin
      drop_cnt_nxt = (drop_cnt_r == DROP_W'(DROP_MIN_CYCLES)) ? drop_cnt_r : drop_cnt_r + DROP_W'(1);
    end
  end

  // Stretched system reset; release of the last held source starts the delay
  rwc_startup_delay #(
    .DW(DELAY_W)
  ) u_delay (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .hold(hold), // R02 R06 R08
    .delay_cycles(startup_delay_period),
    .in_reset_r(sys_reset)
  );

  // Watchdog counter; not gated by any sleep state so it can wake the core
  assign dog_cfg.run = eff_irq || eff_rst; // R16
  assign dog_cfg.psel = psel_r; // R17

  rwc_dog_counter #(
    .CNT_W(DOG_CNT_W)
  ) u_dog (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .cfg(dog_cfg),
    .restart(dog_restart || sys_reset), // R14
    .osc_tick(dog_osc_tick),
    .timeout_r(timeout)
  );

  // Effective enables; the fuse and the watchdog reset flag override software
  assign eff_rst = rst_en_r || cause_r.dog_reset_seen_flag || watchdog_always_on_fuse; // R18 R22
  assign eff_irq = irq_en_r && !watchdog_always_on_fuse; // R18
  assign mode = dog_mode(eff_irq, eff_rst);

  // Timeout action by mode; combined mode resets on a second expiry
  always_comb begin
    fire_irq = 1'b0;
    fire_rst = 1'b0;
    case (mode)
      RWC_DOG_STOPPED: begin
        fire_irq = 1'b0;
      end
      RWC_DOG_IRQ: begin
        fire_irq = timeout; // R15
      end
      RWC_DOG_RESET: begin
        fire_rst = timeout; // R15
      end
      RWC_DOG_BOTH: begin
        fire_irq = timeout && !irq_flag_r; // R15
        fire_rst = timeout && irq_flag_r;
      end
      default: begin
        fire_irq = 1'b0;
      end
    endcase
  end

  // Bus decode; a write lands at the edge that sees waitrequest low
  assign req = avs_read || avs_write;
  assign acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wr_status = acc_wr && (avs_address == ADDR_STATUS);
  assign wr_ctl = acc_wr && (avs_address == ADDR_CONTROL);
  assign wd = rwc_wdctl_s'(avs_writedata[7:0]);
  assign ctl_rd = '{watchdog_irq_flag: irq_flag_r, watchdog_irq_enable: eff_irq, psel_hi: psel_r[3],
                    watchdog_change_unlock: unlock_r, watchdog_reset_enable: eff_rst, psel_lo: psel_r[2:0]};

  // Cause status: hardware set wins over a software clear in the same cycle
  always_comb begin
    cause_nxt = cause_r;
    cause_nxt.zero = 4'h0; // R26
    if (wr_status) begin
      cause_nxt.dog_reset_seen_flag = cause_r.dog_reset_seen_flag && avs_writedata[3];
      cause_nxt.supply_drop_reset_flag = cause_r.supply_drop_reset_flag && avs_writedata[2];
      cause_nxt.pin_reset_flag = cause_r.pin_reset_flag && avs_writedata[1];
      cause_nxt.power_up_reset_flag = cause_r.power_up_reset_flag && avs_writedata[0]; // R12
    end
    if (dog_pulse_r) begin
      cause_nxt.dog_reset_seen_flag = 1'b1; // R09
    end
    if (drop_hold) begin
      cause_nxt.supply_drop_reset_flag = 1'b1; // R10
    end
    if (pin_hold) begin
      cause_nxt.pin_reset_flag = 1'b1; // R11
    end
  end

  // Watchdog control with timed unlock window
  always_comb begin
    irq_en_nxt = irq_en_r;
    rst_en_nxt = rst_en_r;
    psel_nxt = psel_r;
    unlock_nxt = unlock_r;
    ucnt_nxt = ucnt_r;
    if (unlock_r) begin
      ucnt_nxt = ucnt_r + UNL_W'(1);
      if (ucnt_r == UNL_W'(UNLOCK_CYCLES - 1)) begin
        unlock_nxt = 1'b0; // R21
      end
    end
    if (wr_ctl) begin
      irq_en_nxt = wd.watchdog_irq_enable;
      if (wd.watchdog_change_unlock && wd.watchdog_reset_enable) begin
        unlock_nxt = 1'b1; // R19
        ucnt_nxt = '0;
        rst_en_nxt = 1'b1;
      end else if (unlock_r && !wd.watchdog_change_unlock) begin
        rst_en_nxt = wd.watchdog_reset_enable || cause_r.dog_reset_seen_flag; // R20 R22
        psel_nxt = {wd.psel_hi, wd.psel_lo}; // R20
        unlock_nxt = 1'b0;
      end else if (wd.watchdog_reset_enable) begin
        rst_en_nxt = 1'b1; // Setting needs no unlock
      end
    end
    if (dog_irq_ack && eff_rst) begin
      irq_en_nxt = 1'b0; // Vector drops combined mode to reset mode
    end
    if (sys_reset) begin
      unlock_nxt = 1'b0;
    end
  end

  // Interrupt flag and outputs
  assign irq_flag_nxt = (irq_flag_r && !(wr_ctl && wd.watchdog_irq_flag) && !dog_irq_ack) || fire_irq; // R24
  assign dog_irq_nxt = irq_flag_nxt && irq_en_nxt && !watchdog_always_on_fuse;
  assign dog_pulse_nxt = fire_rst && !dog_pulse_r; // R07

  // Read data is captured while waitrequest is still high
  always_comb begin
    wait_nxt = !(req && avs_waitrequest);
    rdata_nxt = avs_readdata;
    if (avs_read && avs_waitrequest) begin
      case (avs_address)
        ADDR_STATUS: rdata_nxt = {24'h000000, cause_r}; // R26
        ADDR_CONTROL: rdata_nxt = {24'h000000, ctl_rd};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_cnt_r <= '0;
      drop_cnt_r <= '0;
      dog_pulse_r <= 1'b0;
      cause_r <= rwc_cause_s'(STATUS_RESET); // R12
      {irq_flag_r, irq_en_r, psel_r[3], unlock_r, rst_en_r, psel_r[2:0]} <= CONTROL_RESET;
      ucnt_r <= '0;
      dog_irq <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else begin
      pin_cnt_r <= pin_cnt_nxt;
      drop_cnt_r <= drop_cnt_nxt;
      dog_pulse_r <= dog_pulse_nxt;
      cause_r <= cause_nxt;
      irq_flag_r <= irq_flag_nxt;
      irq_en_r <= irq_en_nxt;
      psel_r <= psel_nxt;
      unlock_r <= unlock_nxt;
      rst_en_r <= rst_en_nxt;
      ucnt_r <= ucnt_nxt;
      dog_irq <= dog_irq_nxt;
      avs_waitrequest <= wait_nxt;
      avs_readdata <= rdata_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_pin_to_reset: assert property ( // R01
    pin_hold |=> sys_reset) else $error("pin hold did not reset");
  a_release_delay: assert property ( // R02 R06 R08
    ($fell(hold) && startup_delay_period == DELAY_W'(8)) ##1 (!hold)[*8] |-> sys_reset ##1 (hold || !sys_reset))
    else $error("start-up delay length wrong");
  a_drop_at_once: assert property ( // R04
    drop_hold |=> sys_reset && cause_r.supply_drop_reset_flag) else $error("supply drop reset late");
  a_drop_glitch: assert property ( // R05
    $rose(supply_low) |-> (!drop_hold)[*8]) else $error("short drop caused reset");
  a_dog_pulse_one: assert property ( // R07
    dog_pulse_r |=> !dog_pulse_r && cause_r.dog_reset_seen_flag) else $error("watchdog pulse too long");
  a_pin_flag_set: assert property ( // R11
    pin_hold |=> cause_r.pin_reset_flag) else $error("pin flag not set");
  a_power_flag: assert property ( // R12
    cause_r.power_up_reset_flag && !(wr_status && !avs_writedata[0]) |=> cause_r.power_up_reset_flag)
    else $error("power-up flag lost");
  a_fuse_reset: assert property ( // R18
    watchdog_always_on_fuse && timeout |=> dog_pulse_r && !irq_flag_r) else $error("fuse did not force reset");
  a_unlock_close: assert property ( // R21
    $rose(unlock_r) ##0 (!wr_ctl)[*4] |=> !unlock_r) else $error("unlock window wrong length");
  a_flag_keeps_en: assert property ( // R22
    cause_r.dog_reset_seen_flag && wr_ctl && unlock_r && !wd.watchdog_reset_enable |=> rst_en_r)
    else $error("reset enable cleared under flag");
  a_irq_first: assert property ( // R15 R24
    timeout && eff_irq && !irq_flag_r && !watchdog_always_on_fuse |=> irq_flag_r && !dog_pulse_r)
    else $error("interrupt mode timeout wrong");

  // Flag clears, register locks and mode changes; a clear loses to a same-cycle set
  a_drop_off_quiet: assert property ( // R03
    supply_drop_level_select == DROP_LEVEL_OFF |-> !drop_hold)
    else $error("disabled detector caused reset");
  a_dog_flag_clear: assert property ( // R09
    wr_status && !avs_writedata[3] && !dog_pulse_r |=> !cause_r.dog_reset_seen_flag)
    else $error("watchdog flag not cleared");
  a_drop_flag_clear: assert property ( // R10
    wr_status && !avs_writedata[2] && !drop_hold |=> !cause_r.supply_drop_reset_flag)
    else $error("supply drop flag not cleared");
  a_pin_flag_clear: assert property ( // R11
    wr_status && !avs_writedata[1] && !pin_hold |=> !cause_r.pin_reset_flag)
    else $error("pin flag not cleared");
  a_restart_no_expiry: assert property ( // R14
    dog_restart |=> !timeout)
    else $error("restart did not clear count");
  a_status_high_zero: assert property ( // R26
    avs_read && avs_waitrequest && avs_address == ADDR_STATUS |=> avs_readdata[31:4] == 28'h0000000)
    else $error("status upper bits not zero");
  a_fuse_enables: assert property ( // R18
    watchdog_always_on_fuse |-> ctl_rd.watchdog_reset_enable && !ctl_rd.watchdog_irq_enable)
    else $error("fuse did not lock enables");
  a_psel_locked: assert property ( // R20
    wr_ctl && !unlock_r |=> $stable(psel_r))
    else $error("prescaler changed outside window");
  a_reset_en_kept: assert property ( // R20
    wr_ctl && !unlock_r && rst_en_r |=> rst_en_r)
    else $error("reset enable cleared outside window");
  a_combined_reset: assert property ( // R15
    timeout && mode == RWC_DOG_BOTH && irq_flag_r |=> dog_pulse_r)
    else $error("combined mode second expiry did not reset");
  a_ack_to_reset: assert property ( // R15 R24
    dog_irq_ack && eff_rst && !fire_irq |=> !irq_flag_r && !irq_en_r)
    else $error("vector did not drop to reset mode");
  a_pulse_holds: assert property ( // R08
    $fell(dog_pulse_r) |-> sys_reset)
    else $error("reset not held after watchdog pulse");
  a_irq_output: assert property ( // R24
    irq_flag_r && irq_en_r && !watchdog_always_on_fuse |-> dog_irq)
    else $error("interrupt request not raised");
endmodule // rwc_reset_watchdog
`default_nettype wire

//--- verif/rwc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module rwc_far_model #(
  parameter int unsigned TICK_DIV = 2
) (
  // Clock
  input wire logic ref_clk,
  // Commands from the bench
  input wire logic pin_go,
  input wire logic [7:0] pin_len,
  input wire logic drop_go,
  input wire logic [7:0] drop_len,
  // Lines into the block
  output logic reset_pin_n,
  output logic supply_low,
  output logic dog_osc_tick
);
  int unsigned div_r;
  logic [7:0] pin_cnt_r;
  logic [7:0] drop_cnt_r;

  // Start idle: pin pulled up, supply good, oscillator phase zero
  initial begin
    div_r = 0;
    pin_cnt_r = 8'h00;
    drop_cnt_r = 8'h00;
    dog_osc_tick = 1'b0;
  end

  // Oscillator never stops, even while the core sleeps; sped up so timeouts fit the run
  always @(posedge ref_clk) begin
    div_r <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
    dog_osc_tick <= (div_r == TICK_DIV - 1);
    pin_cnt_r <= pin_go ? pin_len : ((pin_cnt_r != 8'h00) ? pin_cnt_r - 8'h01 : 8'h00);
    drop_cnt_r <= drop_go ? drop_len : ((drop_cnt_r != 8'h00) ? drop_cnt_r - 8'h01 : 8'h00);
  end

  // Pin has a pull-up, so it reads high once the pulse is over
  assign reset_pin_n = (pin_cnt_r == 8'h00);
  assign supply_low = (drop_cnt_r != 8'h00);
endmodule // rwc_far_model
`default_nettype wire

//--- verif/tb_reset_and_watchdog_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_reset_and_watchdog_control;
  import rwc_pkg::*;
  logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest, sys_reset, dog_irq;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic reset_pin_n, supply_low, dog_osc_tick, dog_restart, watchdog_always_on_fuse, dog_irq_ack;
  logic [2:0] supply_drop_level_select;
  logic pin_go, drop_go;
  logic [7:0] pin_len, drop_len, rd;
  int n_errors, samples_checked;

  // Block under test with a short start-up delay of 8 cycles
  rwc_reset_watchdog uut (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reset_pin_n(reset_pin_n), .supply_low(supply_low),
    .supply_drop_level_select(supply_drop_level_select), .startup_delay_period(16'h0008),
    .dog_osc_tick(dog_osc_tick), .dog_restart(dog_restart), .dog_irq_ack(dog_irq_ack),
    .watchdog_always_on_fuse(watchdog_always_on_fuse), .sys_reset(sys_reset), .dog_irq(dog_irq));

  // Pin, supply monitor and watchdog oscillator
  rwc_far_model far (.ref_clk(ref_clk), .pin_go(pin_go), .pin_len(pin_len), .drop_go(drop_go),
    .drop_len(drop_len), .reset_pin_n(reset_pin_n), .supply_low(supply_low), .dog_osc_tick(dog_osc_tick));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One Avalon access; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 20) begin
      n_errors++;
      complete_run;
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task rdc(input logic [3:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    check(rd, exp);
  endtask

  // Bounded wait for sys_reset (irq=0) or dog_irq (irq=1) to reach v
  task wait_for(input bit irq, input logic v, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      @(posedge ref_clk);
      if ((irq ? dog_irq : sys_reset) === v) break;
    end
    samples_checked++;
    if (i == lim) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, !v, v);
      complete_run;
    end
  endtask

  // One-cycle command: 0 pin pulse, 1 supply drop, 2 watchdog restart, 3 vector taken
  task fire(input int k);
    @(posedge ref_clk);
    if (k == 0) pin_go <= 1'b1;
    else if (k == 1) drop_go <= 1'b1;
    else if (k == 2) dog_restart <= 1'b1;
    else dog_irq_ack <= 1'b1;
    @(posedge ref_clk);
    pin_go <= 1'b0;
    drop_go <= 1'b0;
    dog_restart <= 1'b0;
    dog_irq_ack <= 1'b0;
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    dog_restart = 1'b0;
    dog_irq_ack = 1'b0;
    watchdog_always_on_fuse = 1'b0;
    supply_drop_level_select = 3'h0;
    pin_go = 1'b0;
    drop_go = 1'b0;
    pin_len = 8'h14;
    drop_len = 8'h64;
    n_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    rdc(ADDR_STATUS, 8'h01);
    rdc(ADDR_CONTROL, 8'h00);
    wr(4'h8, 8'hFF);
    rdc(4'h8, 8'h00);
    wait_for(0, 1'b0, 50);
    wr(ADDR_STATUS, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    $display("test power_up done");
    fire(0);
    repeat (20) @(posedge ref_clk);
    check({7'h00, sys_reset}, 8'h01);
    repeat (4) @(posedge ref_clk);
    check({7'h00, sys_reset}, 8'h01);
    wait_for(0, 1'b0, 40);
    rdc(ADDR_STATUS, 8'h02);
    $display("test pin_reset done");
    fire(1);
    wait_for(0, 1'b1, 120);
    wait_for(0, 1'b0, 200);
    rdc(ADDR_STATUS, 8'h06);
    wr(ADDR_STATUS, 8'h00);
    drop_len <= 8'h28;
    fire(1);
    repeat (130) @(posedge ref_clk);
    check({7'h00, sys_reset}, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    supply_drop_level_select <= DROP_LEVEL_OFF;
    drop_len <= 8'h64;
    fire(1);
    repeat (130) @(posedge ref_clk);
    check({7'h00, sys_reset}, 8'h00);
    rdc(ADDR_STATUS, 8'h00);
    supply_drop_level_select <= 3'h0;
    $display("test supply_drop done");
    fire(2);
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h08);
    rdc(ADDR_CONTROL, 8'h08);
    wait_for(0, 1'b1, 6000);
    wait_for(0, 1'b0, 40);
    rdc(ADDR_STATUS, 8'h08);
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h00);
    rdc(ADDR_CONTROL, 8'h08);
    wr(ADDR_STATUS, 8'h00);
    wr(ADDR_CONTROL, 8'h18);
    repeat (8) @(posedge ref_clk);
    wr(ADDR_CONTROL, 8'h00);
    rdc(ADDR_CONTROL, 8'h08);
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h00);
    rdc(ADDR_CONTROL, 8'h00);
    $display("test dog_reset done");
    wr(ADDR_CONTROL, 8'h18);
    wr(ADDR_CONTROL, 8'h41);
    fire(2);
    repeat (8100) @(posedge ref_clk);
    check({7'h00, dog_irq}, 8'h00);
    wait_for(1, 1'b1, 400);
    rdc(ADDR_CONTROL, 8'hC1);
    wr(ADDR_CONTROL, 8'hC1);
    repeat (2) @(posedge ref_clk);
    check({7'h00, dog_irq}, 8'h00);
    $display("test dog_irq done");
    wr(ADDR_CONTROL, 8'h49);
    fire(2);
    wait_for(1, 1'b1, 8400);
    check({7'h00, sys_reset}, 8'h00);
    fire(3);
    repeat (2) @(posedge ref_clk);
    check({7'h00, dog_irq}, 8'h00);
    rdc(ADDR_CONTROL, 8'h09);
    wait_for(0, 1'b1, 8400);
    wait_for(0, 1'b0, 40);
    rdc(ADDR_STATUS, 8'h08);
    $display("test dog_combined done");
    watchdog_always_on_fuse <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rdc(ADDR_CONTROL, 8'h09);
    $display("test fuse done");
    complete_run;
  end
endmodule // tb_reset_and_watchdog_control
`default_nettype wire
